// ---- dv/card_detect_global_ctrl_regs_asserts.sv ----
`timescale 1ns/1ps
module card_detect_global_ctrl_regs_asserts
    import cdgc_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic i_CE,
    input wire logic i_RD,
    input wire logic i_WR,
    input wire logic i_MEM,
    input wire logic [11:0] i_ADDR,
    input wire logic [7:0] i_WDATA,
    input wire logic [1:0] i_VOLTAGE_SENSE_1,
    input wire logic [1:0] i_VOLTAGE_SENSE_2,
    input wire logic [1:0] i_CD_CHANGE,
    input wire logic [1:0] i_DETECT_IRQ_EN,
    input wire logic [1:0] i_CSC_DETECT_CLEAR,
    input wire logic [7:0] o_RDATA,
    input wire logic [1:0] o_SOFT_DETECT_TRIGGER,
    input wire logic o_RING_INDICATE_OUT,
    input wire logic o_FLAG_CLEAR_BY_WRITE,
    input wire logic o_CARD_OUTPUT_SLEEP
);
    logic cd_a, cd_rd, glb, soft_wr, cd_any, clr_any;
    // decode of socket A detect register and shared global register
    assign cd_a = i_CE && !i_MEM && i_ADDR[7:0] == CDGC_OFF_A;
    assign cd_rd = i_RD && cd_a;
    assign glb = i_CE && (i_MEM ? i_ADDR == GLB_OFF_MEM : i_ADDR[7:0] == GLB_OFF_A);
    assign soft_wr = i_WR && cd_a && i_WDATA[SOFT_TRIG_BIT] && i_DETECT_IRQ_EN[0];
    assign cd_any = |i_CD_CHANGE;
    assign clr_any = |i_CSC_DETECT_CLEAR;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    sequence s_soft_wr;
        soft_wr && !i_CSC_DETECT_CLEAR[0] && !o_FLAG_CLEAR_BY_WRITE ##1 !i_CSC_DETECT_CLEAR[0];
    endsequence
    sequence s_held;
        !o_RING_INDICATE_OUT && !clr_any;
    endsequence
    property p_trig; s_soft_wr |-> ##1 o_SOFT_DETECT_TRIGGER[0]; endproperty
    a_trig: assert property (p_trig) else $error("soft detect pulse missing");
    property p_bit5; o_RDATA[SOFT_TRIG_BIT] == 1'b0; endproperty
    a_bit5: assert property (p_bit5) else $error("bit 5 read back as one");
    property p_rsvd; cd_rd |=> o_RDATA[3:2] == 2'h0 && !o_RDATA[0]; endproperty
    a_rsvd: assert property (p_rsvd) else $error("detect reserved bits set");
    property p_sense;
        cd_rd |=> o_RDATA[7:6] == {$past(i_VOLTAGE_SENSE_2[0]), $past(i_VOLTAGE_SENSE_1[0])};
    endproperty
    a_sense: assert property (p_sense) else $error("sense levels wrong");
    property p_glb_rsvd; i_RD && glb |=> o_RDATA[7:5] == 3'h0; endproperty
    a_glb_rsvd: assert property (p_glb_rsvd) else $error("global reserved set");
    property p_wr_glb;
        i_WR && glb |=> o_CARD_OUTPUT_SLEEP == $past(i_WDATA[0])
            && o_FLAG_CLEAR_BY_WRITE == $past(i_WDATA[2]);
    endproperty
    a_wr_glb: assert property (p_wr_glb) else $error("global write lost");
    property p_ring_fall; $fell(o_RING_INDICATE_OUT) |-> $past(cd_any, 2); endproperty
    a_ring_fall: assert property (p_ring_fall) else $error("ring fell unprompted");
    property p_ring_hold; s_held ##1 s_held |=> !o_RING_INDICATE_OUT; endproperty
    a_ring_hold: assert property (p_ring_hold) else $error("ring released early");
endmodule // card_detect_global_ctrl_regs_asserts
bind card_detect_global_ctrl_regs card_detect_global_ctrl_regs_asserts chk (.*);

// ---- dv/cdgc_far_model.sv ----
`timescale 1ns/1ps
// socket pins and status-change side facing the block
module cdgc_far_model
(
    input wire logic i_clk,
    output logic [1:0] o_sense1,
    output logic [1:0] o_sense2,
    output logic [1:0] o_cd,
    output logic [1:0] o_en,
    output logic [1:0] o_clr,
    output logic [1:0] o_rm
);
    initial {o_sense1, o_sense2, o_cd, o_en, o_clr, o_rm} = 12'h000;
    // raise one event line for n cycles, off the sampling edge
    task automatic pulse(input int k, input int s, input int n);
        @(negedge i_clk);
        case (k)
            0: o_cd[s] = 1'b1;
            1: o_clr[s] = 1'b1;
            default: o_rm[s] = 1'b1;
        endcase
        repeat (n) @(negedge i_clk);
        {o_cd, o_clr, o_rm} = 6'h00;
    endtask
endmodule // cdgc_far_model

// ---- dv/tb_card_detect_global_ctrl_regs.sv ----
`timescale 1ns/1ps
module tb_card_detect_global_ctrl_regs
    import cdgc_pkg::*;
;
    logic I_CLK = 1'b0, I_RST = 1'b1, i_CE = 1'b1, i_RD = 1'b0, i_WR = 1'b0, i_MEM = 1'b0;
    logic [11:0] i_ADDR = 12'h000;
    logic [7:0] i_WDATA = 8'h00, o_RDATA;
    logic [1:0] i_VOLTAGE_SENSE_1, i_VOLTAGE_SENSE_2, i_CD_CHANGE, i_DETECT_IRQ_EN;
    logic [1:0] i_CSC_DETECT_CLEAR, i_CARD_REMOVED, o_SOFT_DETECT_TRIGGER, o_REMOVAL_RESET;
    logic o_RING_INDICATE_OUT, o_SOCKET_A_IRQ_LEVEL, o_SOCKET_B_IRQ_LEVEL;
    logic o_FLAG_CLEAR_BY_WRITE, o_STATUS_CHANGE_IRQ_LEVEL, o_CARD_OUTPUT_SLEEP;
    int errors = 0, cmp_count = 0;
    wire [7:0] glb_o = {3'h0, o_SOCKET_B_IRQ_LEVEL, o_SOCKET_A_IRQ_LEVEL,
        o_FLAG_CLEAR_BY_WRITE, o_STATUS_CHANGE_IRQ_LEVEL, o_CARD_OUTPUT_SLEEP};
    card_detect_global_ctrl_regs uut (.*);
    cdgc_far_model m (.i_clk(I_CLK), .o_sense1(i_VOLTAGE_SENSE_1), .o_sense2(i_VOLTAGE_SENSE_2),
        .o_cd(i_CD_CHANGE), .o_en(i_DETECT_IRQ_EN), .o_clr(i_CSC_DETECT_CLEAR), .o_rm(i_CARD_REMOVED));
    always #20 I_CLK = ~I_CLK;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one-cycle register access, changed at falling edges
    task automatic acc(input logic w, input logic mem, input logic [11:0] a, input logic [7:0] d);
        @(negedge I_CLK);
        {i_WR, i_RD, i_MEM, i_ADDR, i_WDATA} = {w, !w, mem, a, d};
        @(negedge I_CLK);
        {i_WR, i_RD} = 2'b00;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        acc(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic mem, input logic [11:0] a, input logic [7:0] exp);
        acc(1'b0, mem, a, 8'h00);
        chk(o_RDATA, exp);
    endtask
    task automatic t_regs();
        rd(1'b0, 12'h01E, 8'h00);
        wr(12'h016, 8'hFF);
        for (int i = 0; i < 4; i++)
        begin
            m.o_sense1 = i[1:0];
            m.o_sense2 = ~i[1:0];
            rd(1'b0, 12'h016, {~i[0], i[0], 6'h12});
            rd(1'b1, 12'h856, {~i[1], i[1], 6'h00});
        end
        wr(12'h016, 8'h00);
    endtask
    task automatic t_glb();
        wr(12'h01E, 8'hFF);
        rd(1'b0, 12'h05E, 8'h1F);
        rd(1'b1, 12'h81E, 8'h1F);
        chk(glb_o, 8'h1F);
        wr(12'h05E, 8'h0A);
        rd(1'b0, 12'h01E, 8'h0A);
        chk(glb_o, 8'h0A);
        rd(1'b0, 12'h01F, 8'h00);
        wr(12'h05E, 8'h00);
    endtask
    task automatic t_trig();
        wr(12'h016, 8'h20);
        @(negedge I_CLK);
        chk({6'h00, o_SOFT_DETECT_TRIGGER}, 8'h00);
        m.o_en = 2'b11;
        wr(12'h016, 8'h20);
        @(negedge I_CLK);
        chk({6'h00, o_SOFT_DETECT_TRIGGER}, 8'h01);
        @(negedge I_CLK);
        chk({6'h00, o_SOFT_DETECT_TRIGGER}, 8'h00);
        wr(12'h01E, 8'h04);
        fork
            wr(12'h016, 8'h20);
            m.pulse(1, 0, 2);
        join
        chk({6'h00, o_SOFT_DETECT_TRIGGER}, 8'h00);
        wr(12'h01E, 8'h00);
    endtask
    task automatic t_ring();
        m.pulse(0, 0, 1);
        repeat (2) @(negedge I_CLK);
        chk({7'h00, o_RING_INDICATE_OUT}, 8'h01);
        wr(12'h016, 8'h10);
        m.pulse(0, 0, 1);
        @(negedge I_CLK);
        chk({7'h00, o_RING_INDICATE_OUT}, 8'h00);
        m.pulse(1, 1, 1);
        repeat (6) @(negedge I_CLK);
        chk({7'h00, o_RING_INDICATE_OUT}, 8'h00);
        m.pulse(1, 0, 1);
        @(negedge I_CLK);
        chk({7'h00, o_RING_INDICATE_OUT}, 8'h01);
    endtask
    task automatic t_rm();
        for (int e = 0; e < 2; e++)
        begin
            wr(12'h016, {6'h00, e[0], 1'b0});
            fork
                m.pulse(2, 0, 1);
                begin
                    repeat (2) @(negedge I_CLK);
                    chk({6'h00, o_REMOVAL_RESET}, {7'h00, e[0]});
                end
            join
        end
    endtask
    // clock enable low: a global write must not land
    task automatic t_ce();
        @(negedge I_CLK);
        i_CE = 1'b0;
        wr(12'h01E, 8'h1F);
        chk(glb_o, 8'h00);
        @(negedge I_CLK);
        i_CE = 1'b1;
        rd(1'b0, 12'h01E, 8'h00);
    endtask
    task automatic conclude();
        if (errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // reset, then the scenarios in turn
    initial
    begin
        repeat (10) @(negedge I_CLK);
        I_RST = 1'b0;
        t_regs();
        t_glb();
        t_trig();
        t_ring();
        t_rm();
        t_ce();
        conclude();
    end
    initial
    begin
        #100000;
        errors++;
        conclude();
    end
endmodule // tb_card_detect_global_ctrl_regs

// ---- logic/card_detect_global_ctrl_regs.sv ----
`timescale 1ns/1ps
// Function
// - bit 7 reads live second sense level
// - bit 6 reads live first sense level
// - writing bit 5 raises detect interrupt if enabled
// - bit 5 reads zero, self clears
// - write-back clear mode also clears soft trigger
// - wake enable: detect change pulls ring low
// - ring stays low until status clear
// - bits 3, 2, 0 read zero
// - bit 1 resets socket registers on removal
// - one global register shared by sockets
// - global decodes at 81E, 1E, 5E
// - global bit 2 selects flag clear method
// - global bits 4,3,1 select level interrupts
// - global bit 0 sleeps card outputs
// - global bits 7 to 5 read zero
module card_detect_global_ctrl_regs
    import cdgc_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic i_CE,
    input wire logic i_RD,
    input wire logic i_WR,
    input wire logic i_MEM,
    input wire logic [11:0] i_ADDR,
    input wire logic [7:0] i_WDATA,
    input wire logic [1:0] i_VOLTAGE_SENSE_1,
    input wire logic [1:0] i_VOLTAGE_SENSE_2,
    input wire logic [1:0] i_CD_CHANGE,
    input wire logic [1:0] i_DETECT_IRQ_EN,
    input wire logic [1:0] i_CSC_DETECT_CLEAR,
    input wire logic [1:0] i_CARD_REMOVED,
    output logic [7:0] o_RDATA,
    output logic [1:0] o_SOFT_DETECT_TRIGGER,
    output logic o_RING_INDICATE_OUT,
    output logic [1:0] o_REMOVAL_RESET,
    output logic o_SOCKET_A_IRQ_LEVEL,
    output logic o_SOCKET_B_IRQ_LEVEL,
    output logic o_FLAG_CLEAR_BY_WRITE,
    output logic o_STATUS_CHANGE_IRQ_LEVEL,
    output logic o_CARD_OUTPUT_SLEEP
);
    reg_req_t req;
    glb_ctl_t glb_r;
    logic [7:0] glb_rd;
    logic [1:0] sel_cd;
    logic sel_glb;
    logic [7:0] cd_rd [2];
    logic [1:0] trig;
    logic [1:0] ring_low;
    logic [1:0] rem_rst;
    logic [1:0] csc_clr;
    logic [7:0] rdata_r;
    logic ring_r;
    logic [1:0] trig_r;
    logic [1:0] rem_r;
    logic [11:0] mem_cd_a;
    logic [11:0] mem_cd_b;
    logic [1:0] idx_cd_hit;
    logic [1:0] mem_cd_hit;
    logic idx_glb_hit;
    logic mem_glb_hit;
    logic [1:0] wr_cd;
    logic wr_glb;
    logic [7:0] glb_wval;
    logic [7:0] rd_mux;

    assign req = '{rd: i_RD, wr: i_WR, mem: i_MEM, addr: i_ADDR, wdata: i_WDATA};

    // memory-view offsets of the two detect registers
    assign mem_cd_a = MEM_BASE | {4'h0, CDGC_OFF_A};
    assign mem_cd_b = MEM_SOCK_B | {4'h0, CDGC_OFF_A};

    // index view: low byte only; global answers in both socket windows
    always_comb
    begin
        idx_cd_hit[0] = (req.addr[7:0] == CDGC_OFF_A);
        idx_cd_hit[1] = (req.addr[7:0] == CDGC_OFF_B);
        idx_glb_hit = (req.addr[7:0] == GLB_OFF_A) || (req.addr[7:0] == GLB_OFF_B);
    end

    // memory view: full offset; global only at its single shared slot
    always_comb
    begin
        mem_cd_hit[0] = (req.addr == mem_cd_a);
        mem_cd_hit[1] = (req.addr == mem_cd_b);
        mem_glb_hit = (req.addr == GLB_OFF_MEM);
    end

    // the request's view picks which decode counts
    always_comb
    begin
        sel_cd = req.mem ? mem_cd_hit : idx_cd_hit;
        sel_glb = req.mem ? mem_glb_hit : idx_glb_hit;
    end

    // write strobes, one per storage target
    assign wr_cd = sel_cd & {2{req.wr}};
    assign wr_glb = req.wr && sel_glb;

    // only the five control bits take data; bits 7..5 never store
    assign glb_wval = req.wdata & GLB_WMASK;

    // status-change clear also ends soft trigger in write-back mode
    assign csc_clr = i_CSC_DETECT_CLEAR & {2{glb_r.clr_write}};

    // one detect and control register per socket
    genvar s;
    generate
        for (s = 0; s < 2; s++)
        begin : g_sock
            cd_socket_ctl u_sock (
                .i_clk(I_CLK),
                .i_rst(I_RST),
                .i_ce(i_CE),
                .i_wr(wr_cd[s]),
                .i_wdata(req.wdata),
                .i_sense1(i_VOLTAGE_SENSE_1[s]),
                .i_sense2(i_VOLTAGE_SENSE_2[s]),
                .i_cd_change(i_CD_CHANGE[s]),
                .i_detect_irq_en(i_DETECT_IRQ_EN[s]),
                .i_csc_clear(i_CSC_DETECT_CLEAR[s]),
                .i_card_removed(i_CARD_REMOVED[s]),
                .o_rdata(cd_rd[s]),
                .o_soft_trigger(trig[s]),
                .o_ring_low(ring_low[s]),
                .o_removal_reset(rem_rst[s])
            );
        end
    endgenerate

    // single shared global control register
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            glb_r <= '0;
        else if (i_CE && wr_glb)
        begin
            glb_r.sockb_lvl <= glb_wval[SOCKB_LVL_BIT];
            glb_r.socka_lvl <= glb_wval[SOCKA_LVL_BIT];
            glb_r.clr_write <= glb_wval[CLR_WRITE_BIT];
            glb_r.csc_lvl <= glb_wval[CSC_LVL_BIT];
            glb_r.sleep <= glb_wval[SLEEP_BIT];
        end
    end

    // global read view, upper bits zero
    always_comb
    begin
        glb_rd = RESET_VAL;
        glb_rd[SOCKB_LVL_BIT] = glb_r.sockb_lvl;
        glb_rd[SOCKA_LVL_BIT] = glb_r.socka_lvl;
        glb_rd[CLR_WRITE_BIT] = glb_r.clr_write;
        glb_rd[CSC_LVL_BIT] = glb_r.csc_lvl;
        glb_rd[SLEEP_BIT] = glb_r.sleep;
    end

    // read mux: zero when idle or unmapped; global wins a shared hit
    always_comb
    begin
        rd_mux = RESET_VAL;
        if (req.rd)
        begin
            if (sel_glb)
                rd_mux = glb_rd;
            else if (sel_cd[0])
                rd_mux = cd_rd[0];
            else if (sel_cd[1])
                rd_mux = cd_rd[1];
        end
    end

    // registered read data, one cycle after the read edge
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            rdata_r <= RESET_VAL;
        else if (i_CE)
            rdata_r <= rd_mux;
    end

    // soft trigger output, cancelled by a write-back status clear
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            trig_r <= 2'b00;
        else if (i_CE)
            trig_r <= trig & ~csc_clr;
    end

    // ring indicate, idle high, low while any socket holds a wake
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            ring_r <= 1'b1;
        else if (i_CE)
            ring_r <= ~|ring_low;
    end

    // removal reset request per socket
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            rem_r <= 2'b00;
        else if (i_CE)
            rem_r <= rem_rst;
    end

    // outputs: each straight from a flop
    assign o_RDATA = rdata_r;
    assign o_SOFT_DETECT_TRIGGER = trig_r;
    assign o_RING_INDICATE_OUT = ring_r;
    assign o_REMOVAL_RESET = rem_r;

    // global control levels
    assign o_SOCKET_A_IRQ_LEVEL = glb_r.socka_lvl;
    assign o_SOCKET_B_IRQ_LEVEL = glb_r.sockb_lvl;
    assign o_FLAG_CLEAR_BY_WRITE = glb_r.clr_write;
    assign o_STATUS_CHANGE_IRQ_LEVEL = glb_r.csc_lvl;
    assign o_CARD_OUTPUT_SLEEP = glb_r.sleep;
endmodule // card_detect_global_ctrl_regs

// ---- logic/cd_socket_ctl.sv ----
`timescale 1ns/1ps
// one socket's card detect and general control register
module cd_socket_ctl
    import cdgc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic i_sense1,
    input wire logic i_sense2,
    input wire logic i_cd_change,
    input wire logic i_detect_irq_en,
    input wire logic i_csc_clear,
    input wire logic i_card_removed,
    output logic [7:0] o_rdata,
    output logic o_soft_trigger,
    output logic o_ring_low,
    output logic o_removal_reset
);
    logic wake_en_r;
    logic removal_r;
    logic ring_low_r;
    logic trig_r;

    // writable bits, cleared by bus reset
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wake_en_r <= 1'b0;
            removal_r <= 1'b0;
        end
        else if (i_ce && i_wr)
        begin
            wake_en_r <= i_wdata[WAKE_EN_BIT];
            removal_r <= i_wdata[REMOVAL_BIT];
        end
    end

    // soft trigger: one-cycle pulse, self-clearing
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            trig_r <= 1'b0;
        else if (i_ce)
            trig_r <= i_wr && i_wdata[SOFT_TRIG_BIT] && i_detect_irq_en;
    end

    // ring indicate held low until status-change clear; set wins
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            ring_low_r <= 1'b0;
        else if (i_ce)
        begin
            if (wake_en_r && i_cd_change)
                ring_low_r <= 1'b1;
            else if (i_csc_clear)
                ring_low_r <= 1'b0;
        end
    end

    // read view: live sense levels, trigger reads zero
    always_comb
    begin
        o_rdata = RESET_VAL;
        o_rdata[SENSE2_BIT] = i_sense2;
        o_rdata[SENSE1_BIT] = i_sense1;
        o_rdata[WAKE_EN_BIT] = wake_en_r;
        o_rdata[REMOVAL_BIT] = removal_r;
    end

    assign o_soft_trigger = trig_r;
    assign o_ring_low = ring_low_r;
    assign o_removal_reset = removal_r && i_card_removed;
endmodule // cd_socket_ctl

// ---- logic/cdgc_pkg.sv ----
package cdgc_pkg;
    // register byte offsets within the socket register view
    localparam logic [7:0] CDGC_OFF_A = 8'h16;
    localparam logic [7:0] CDGC_OFF_B = 8'h56;
    localparam logic [7:0] GLB_OFF_A = 8'h1E;
    localparam logic [7:0] GLB_OFF_B = 8'h5E;
    localparam logic [11:0] GLB_OFF_MEM = 12'h81E;
    localparam logic [11:0] MEM_BASE = 12'h800;
    localparam logic [11:0] MEM_SOCK_B = 12'h840;
    // card detect / general control fields
    localparam int SENSE2_BIT = 7;
    localparam int SENSE1_BIT = 6;
    localparam int SOFT_TRIG_BIT = 5;
    localparam int WAKE_EN_BIT = 4;
    localparam int REMOVAL_BIT = 1;
    // global control fields
    localparam int SOCKB_LVL_BIT = 4;
    localparam int SOCKA_LVL_BIT = 3;
    localparam int CLR_WRITE_BIT = 2;
    localparam int CSC_LVL_BIT = 1;
    localparam int SLEEP_BIT = 0;
    localparam logic [7:0] CDGC_WMASK = 8'h12;
    localparam logic [7:0] GLB_WMASK = 8'h1F;
    localparam logic [7:0] RESET_VAL = 8'h00;

    // register access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic mem;
        logic [11:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // global control decoded outputs
    typedef struct packed {
        logic sockb_lvl;
        logic socka_lvl;
        logic clr_write;
        logic csc_lvl;
        logic sleep;
    } glb_ctl_t;
endpackage
